/* File: hw/backlight_cfg_pkg.sv */
package backlight_cfg_pkg;

	// ------------------------------------------------------------------
	// Register offsets, as carried in the register address byte
	// ------------------------------------------------------------------
	localparam logic [7:0]  OFS_BRIGHTNESS = 8'h00;
	localparam logic [7:0]  OFS_CURRENT    = 8'h02;
	localparam logic [7:0]  OFS_CONTROLS   = 8'h04;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_BRIGHTNESS = 16'h0000;
	localparam logic [15:0] RST_CURRENT    = 16'h0fff;
	localparam logic [15:0] RST_CONTROLS   = 16'h08a3;
	localparam logic [15:0] RST_READ_WORD  = 16'h0000;

	// ------------------------------------------------------------------
	// Field positions in the registers
	// ------------------------------------------------------------------
	localparam int POS_LEVEL_LO  = 0;
	localparam int POS_RANDOM    = 14;
	localparam int POS_RATE_LO   = 12;
	localparam int POS_DEV_LO    = 10;
	localparam int POS_SRC_LO    = 8;
	localparam int POS_RAMP_LO   = 5;
	localparam int POS_DITHER_LO = 2;
	localparam int POS_SMOOTH    = 1;

	// ------------------------------------------------------------------
	// Field codes and decode tables
	// ------------------------------------------------------------------
	localparam logic [1:0]  SRC_PWM_PIN  = 2'h0;
	localparam logic [1:0]  SRC_REGISTER = 2'h2;
	localparam logic [2:0]  RAMP_OFF     = 3'h0;
	localparam logic [2:0]  DITHER_OFF   = 3'h0;
	localparam logic [2:0]  DITHER_MAX   = 3'h4;

	// Modulation rate in Hz, indexed by the rate code.
	localparam logic [10:0] RATE_HZ [4] = '{11'h0c8, 11'h1f4, 11'h320, 11'h4b0};
	// Deviation in tenths of a percent, indexed by the deviation code.
	localparam logic [6:0]  DEV_TENTHS [4] = '{7'h21, 7'h2b, 7'h35, 7'h48};
	// Linear ramp time in ms, indexed by the ramp code.
	localparam logic [8:0]  RAMP_MS [8] = '{9'h000, 9'h001, 9'h002, 9'h032,
		9'h064, 9'h0c8, 9'h12c, 9'h1f4};

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {SEL_NONE, SEL_BRIGHTNESS, SEL_CURRENT, SEL_CONTROLS} reg_sel_t;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_ACK, ST_RDATA, ST_RACK
	} link_state_t;

endpackage

/* File: hw/backlight_cfg_regs.sv */
`timescale 1ns/1ps

// Summary of operation
// - Brightness word resets zero, used when source=2.
// - Two-bit source select resets to PWM pin.
// - Twelve-bit drive level resets FFF, upper reserved.
// - Spread rate decodes 200/500/800/1200 Hz.
// - Spread deviation decodes 3.3/4.3/5.3/7.2 percent.
// - Bit fourteen enables pseudo-random spreading.
// - Ramp code zero off, else 1..500 ms.
// - Smoothed ramp lengthens and shapes transitions.
// - Dither code zero off, one to four bits.
// - Shape bit one selects smoothed ramping.
// - Write is address, offset, two data bytes.
// - Read is address, offset, readdress, two bytes.
// - Writes accepted in standby and normal operation.

module backlight_cfg_regs #(
	parameter logic [6:0] TARGET_ADDR = 7'h2a    // Arbitrary bus address.
) (
	// System clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Serial link.
	input  wire logic        scl_clk,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_b,
	// Brightness and current.
	output logic [15:0]      brightness_value,
	output logic             brightness_from_register,
	output logic [1:0]       brightness_source_select,
	output logic [11:0]      string_drive_level,
	// Ramp and dither.
	output logic             ramp_enable,
	output logic [8:0]       ramp_linear_ms,
	output logic             smooth_ramp_enable,
	output logic             smooth_ramp_active,
	output logic             dither_enable,
	output logic [2:0]       dither_bits,
	// Boost spread spectrum.
	output logic [10:0]      spread_modulation_rate,
	output logic [6:0]       spread_deviation,
	output logic             random_spread_enable
);

	// ------------------------------------------------------------------
	// Link engine
	// ------------------------------------------------------------------
	logic        wr_tog, rd_req_tog;
	logic [7:0]  wr_addr, rd_addr;
	logic [15:0] wr_data;
	logic        rd_ack_q, rd_ack_d;
	logic [15:0] rd_data_q, rd_data_d;

	serial_link #(
		.TARGET_ADDR(TARGET_ADDR)
	) u_link (
		.scl_clk    (scl_clk),
		.rst_b      (rst_b),
		.sda_in     (sda_in),
		.sda_out    (sda_out),
		.sda_oe_b   (sda_oe_b),
		.wr_tog     (wr_tog),
		.wr_addr    (wr_addr),
		.wr_data    (wr_data),
		.rd_req_tog (rd_req_tog),
		.rd_addr    (rd_addr),
		.rd_ack_tog (rd_ack_q),
		.rd_word    (rd_data_q)
	);

	// ------------------------------------------------------------------
	// Crossing into the system clock
	// ------------------------------------------------------------------
	logic wr_s1_q, wr_s2_q, wr_seen_q;
	logic rd_s1_q, rd_s2_q, rd_seen_q;
	logic wr_pulse, rd_pulse;

	// Toggles pass two flops; the words they announce are held still by the link
	// until the next toggle, which is many bus bits away.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wr_s1_q   <= 1'b0;
			wr_s2_q   <= 1'b0;
			wr_seen_q <= 1'b0;
			rd_s1_q   <= 1'b0;
			rd_s2_q   <= 1'b0;
			rd_seen_q <= 1'b0;
		end else begin
			wr_s1_q   <= wr_tog;
			wr_s2_q   <= wr_s1_q;
			wr_seen_q <= wr_s2_q;
			rd_s1_q   <= rd_req_tog;
			rd_s2_q   <= rd_s1_q;
			rd_seen_q <= rd_s2_q;
		end
	end

	assign wr_pulse = wr_s2_q ^ wr_seen_q;
	assign rd_pulse = rd_s2_q ^ rd_seen_q;

	// ------------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------------
	logic [15:0] bright_q, bright_d, level_q, level_d, ctrl_q, ctrl_d;

	// Offset decode, shared by the write and read paths.
	function automatic backlight_cfg_pkg::reg_sel_t sel_of(input logic [7:0] ofs);
		case (ofs)
			backlight_cfg_pkg::OFS_BRIGHTNESS: sel_of = backlight_cfg_pkg::SEL_BRIGHTNESS;
			backlight_cfg_pkg::OFS_CURRENT:    sel_of = backlight_cfg_pkg::SEL_CURRENT;
			backlight_cfg_pkg::OFS_CONTROLS:   sel_of = backlight_cfg_pkg::SEL_CONTROLS;
			default:                           sel_of = backlight_cfg_pkg::SEL_NONE;
		endcase
	endfunction

	// Whole words are stored; reserved bits keep what was written, as they are
	// read-write. No operating state gates the writes.
	always_comb begin
		bright_d  = bright_q;
		level_d   = level_q;
		ctrl_d    = ctrl_q;
		rd_ack_d  = rd_ack_q;
		rd_data_d = rd_data_q;
		if (wr_pulse) begin
			case (sel_of(wr_addr))
				backlight_cfg_pkg::SEL_BRIGHTNESS: bright_d = wr_data;
				backlight_cfg_pkg::SEL_CURRENT:    level_d  = wr_data;
				backlight_cfg_pkg::SEL_CONTROLS:   ctrl_d   = wr_data;
				default: ;
			endcase
		end
		// Unmapped offsets read as zero.
		if (rd_pulse) begin
			rd_ack_d = ~rd_ack_q;
			case (sel_of(rd_addr))
				backlight_cfg_pkg::SEL_BRIGHTNESS: rd_data_d = bright_q;
				backlight_cfg_pkg::SEL_CURRENT:    rd_data_d = level_q;
				backlight_cfg_pkg::SEL_CONTROLS:   rd_data_d = ctrl_q;
				default:                           rd_data_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			bright_q  <= backlight_cfg_pkg::RST_BRIGHTNESS;
			level_q   <= backlight_cfg_pkg::RST_CURRENT;
			ctrl_q    <= backlight_cfg_pkg::RST_CONTROLS;
			rd_ack_q  <= 1'b0;
			rd_data_q <= backlight_cfg_pkg::RST_READ_WORD;
		end else begin
			bright_q  <= bright_d;
			level_q   <= level_d;
			ctrl_q    <= ctrl_d;
			rd_ack_q  <= rd_ack_d;
			rd_data_q <= rd_data_d;
		end
	end

	// ------------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------------
	logic [1:0] src_f, rate_f, dev_f;
	logic [2:0] ramp_f, dith_f;

	assign src_f  = ctrl_q[backlight_cfg_pkg::POS_SRC_LO +: 2];
	assign rate_f = ctrl_q[backlight_cfg_pkg::POS_RATE_LO +: 2];
	assign dev_f  = ctrl_q[backlight_cfg_pkg::POS_DEV_LO +: 2];
	assign ramp_f = ctrl_q[backlight_cfg_pkg::POS_RAMP_LO +: 3];
	assign dith_f = ctrl_q[backlight_cfg_pkg::POS_DITHER_LO +: 3];

	// Outputs are registered one cycle behind the bank; the datapaths see a
	// consistent word because the bank itself only changes whole.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			brightness_value         <= backlight_cfg_pkg::RST_BRIGHTNESS;
			brightness_from_register <= 1'b0;
			brightness_source_select <= backlight_cfg_pkg::SRC_PWM_PIN;
			string_drive_level       <= backlight_cfg_pkg::RST_CURRENT[11:0];
			ramp_enable              <= 1'b0;
			ramp_linear_ms           <= 9'h000;
			smooth_ramp_enable       <= 1'b0;
			smooth_ramp_active       <= 1'b0;
			dither_enable            <= 1'b0;
			dither_bits              <= 3'h0;
			spread_modulation_rate   <= 11'h000;
			spread_deviation         <= 7'h00;
			random_spread_enable     <= 1'b0;
		end else begin
			brightness_value         <= bright_q;
			brightness_from_register <= (src_f == backlight_cfg_pkg::SRC_REGISTER);
			brightness_source_select <= src_f;
			string_drive_level       <= level_q[backlight_cfg_pkg::POS_LEVEL_LO +: 12];
			ramp_enable              <= (ramp_f != backlight_cfg_pkg::RAMP_OFF);
			ramp_linear_ms           <= backlight_cfg_pkg::RAMP_MS[ramp_f];
			smooth_ramp_enable       <= ctrl_q[backlight_cfg_pkg::POS_SMOOTH];
			// The ramp engine stretches and shapes only when a ramp is running.
			smooth_ramp_active       <= ctrl_q[backlight_cfg_pkg::POS_SMOOTH] &
				(ramp_f != backlight_cfg_pkg::RAMP_OFF);
			// Codes above four are held as four so the dither never overruns.
			dither_enable            <= (dith_f != backlight_cfg_pkg::DITHER_OFF);
			dither_bits              <= (dith_f > backlight_cfg_pkg::DITHER_MAX)
				? backlight_cfg_pkg::DITHER_MAX : dith_f;
			spread_modulation_rate   <= backlight_cfg_pkg::RATE_HZ[rate_f];
			spread_deviation         <= backlight_cfg_pkg::DEV_TENTHS[dev_f];
			random_spread_enable     <= ctrl_q[backlight_cfg_pkg::POS_RANDOM];
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_bright_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_pulse && (wr_addr == backlight_cfg_pkg::OFS_BRIGHTNESS)
		|-> ##2 brightness_value == $past(wr_data, 2))
		else $error("brightness word not taken from write");

	a_src_register: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(src_f) == 2'h2 |-> brightness_from_register && brightness_source_select == 2'h2)
		else $error("register brightness source not flagged");

	a_level_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(rst_b, 2) == 1'b0 && !$past(wr_pulse) |-> string_drive_level == 12'hfff)
		else $error("drive level not at reset value");

	a_rate_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(rate_f) == 2'h3 |-> spread_modulation_rate == 11'h4b0)
		else $error("fastest spread rate not 1200 Hz");

	a_dev_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(dev_f) == 2'h0 |-> spread_deviation == 7'h21)
		else $error("smallest deviation not 3.3 percent");

	a_random_spread: assert property (@(posedge clk_sys) disable iff (!rst_b)
		random_spread_enable == $past(ctrl_q[14]))
		else $error("pseudo-random enable does not follow bit");

	a_ramp_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(ramp_f) == 3'h7 |-> ramp_enable && ramp_linear_ms == 9'h1f4)
		else $error("longest ramp not 500 ms");

	// Checked against the stored word, so a broken gate cannot hide behind its own outputs.
	a_smooth_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(rst_b) |-> smooth_ramp_active ==
			($past(ctrl_q[backlight_cfg_pkg::POS_SMOOTH]) && $past(ramp_f) != 3'h0))
		else $error("smoothing active flag does not match shape bit and ramp");

	a_dither_depth: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(dith_f) == 3'h0 |-> !dither_enable && dither_bits == 3'h0)
		else $error("dither not off for code zero");

	a_word_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!wr_pulse |=> $stable(ctrl_q) && $stable(level_q) && $stable(bright_q))
		else $error("register changed without a whole write");

	a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_pulse && (rd_addr == backlight_cfg_pkg::OFS_CURRENT)
		|=> rd_ack_q != $past(rd_ack_q) && rd_data_q == $past(level_q))
		else $error("read answer missing or wrong");

endmodule

/* File: hw/serial_link.sv */
`timescale 1ns/1ps

// Serial target engine. It runs entirely on the bus clock: data is
// sampled on the rising edge and all state moves on the falling edge.
module serial_link #(
	parameter logic [6:0] TARGET_ADDR = 7'h2a
) (
	// Link side.
	input  wire logic        scl_clk,
	input  wire logic        rst_b,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_b,
	// Toward the register bank, crossed by toggles.
	output logic             wr_tog,
	output logic [7:0]       wr_addr,
	output logic [15:0]      wr_data,
	output logic             rd_req_tog,
	output logic [7:0]       rd_addr,
	input  wire logic        rd_ack_tog,
	input  wire logic [15:0] rd_word
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	backlight_cfg_pkg::link_state_t state_q, state_d, after_q, after_d;
	logic        bit_q;
	logic        lrst_q1, lrst_q2;
	logic        ack_s1_q, ack_s2_q, ack_seen_q, ack_seen_d;
	logic [2:0]  cnt_q, cnt_d;
	logic [7:0]  shift_q, shift_d, tx_q, tx_d, hi_q, hi_d, raddr_q, raddr_d;
	logic        idx_q, idx_d, oe_q, oe_d;
	logic        wtog_q, wtog_d, rtog_q, rtog_d;
	logic [7:0]  waddr_q, waddr_d;
	logic [15:0] wdata_q, wdata_d, rword_q, rword_d;
	logic [7:0]  byte_in;
	logic        start_cond, stop_cond;

	// Data is taken while the clock is high.
	always_ff @(posedge scl_clk) begin
		bit_q <= sda_in;
	end

	// Reset and the read answer come from the system clock, so each passes two flops.
	always_ff @(negedge scl_clk) begin
		lrst_q1  <= rst_b;
		lrst_q2  <= lrst_q1;
		ack_s1_q <= rd_ack_tog;
		ack_s2_q <= ack_s1_q;
	end

	// ------------------------------------------------------------------
	// Frame sequencer
	// ------------------------------------------------------------------
	// A data line that differs between the high and the following low edge moved
	// while the clock was high: a fall is a start, a rise is a stop.
	always_comb begin
		start_cond = bit_q & ~sda_in;
		stop_cond  = ~bit_q & sda_in;
		byte_in    = {shift_q[6:0], bit_q};
		state_d = state_q;
		after_d = after_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		tx_d    = tx_q;
		hi_d    = hi_q;
		raddr_d = raddr_q;
		idx_d   = idx_q;
		oe_d    = oe_q;
		wtog_d  = wtog_q;
		rtog_d  = rtog_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		rword_d = rword_q;
		ack_seen_d = ack_s2_q;
		if (ack_s2_q != ack_seen_q) begin
			rword_d = rd_word;
		end
		if (start_cond) begin
			state_d = backlight_cfg_pkg::ST_ADDR;
			cnt_d   = 3'h0;
			oe_d    = 1'b1;
		end else if (stop_cond) begin
			state_d = backlight_cfg_pkg::ST_IDLE;
			oe_d    = 1'b1;
		end else begin
			case (state_q)
				backlight_cfg_pkg::ST_ADDR, backlight_cfg_pkg::ST_REG,
				backlight_cfg_pkg::ST_WDATA: begin
					shift_d = byte_in;
					cnt_d   = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						oe_d    = 1'b0;
						state_d = backlight_cfg_pkg::ST_ACK;
						if (state_q == backlight_cfg_pkg::ST_ADDR) begin
							idx_d   = 1'b0;
							after_d = byte_in[0] ? backlight_cfg_pkg::ST_RDATA
								: backlight_cfg_pkg::ST_REG;
							if (byte_in[7:1] != TARGET_ADDR) begin
								oe_d    = 1'b1;
								state_d = backlight_cfg_pkg::ST_IDLE;
							end
						end else if (state_q == backlight_cfg_pkg::ST_REG) begin
							raddr_d = byte_in;
							rtog_d  = ~rtog_q;        // Fetch the word ahead of a read.
							idx_d   = 1'b0;
							after_d = backlight_cfg_pkg::ST_WDATA;
						end else if (!idx_q) begin
							hi_d    = byte_in;
							idx_d   = 1'b1;
							after_d = backlight_cfg_pkg::ST_WDATA;
						end else begin
							waddr_d = raddr_q;        // Offset then two bytes, high first.
							wdata_d = {hi_q, byte_in};
							wtog_d  = ~wtog_q;        // One event for the whole word.
							after_d = backlight_cfg_pkg::ST_IDLE;
						end
					end
				end
				backlight_cfg_pkg::ST_ACK: begin
					oe_d    = 1'b1;
					cnt_d   = 3'h0;
					state_d = after_q;
					if (after_q == backlight_cfg_pkg::ST_RDATA) begin
						tx_d = rword_q[15:8];         // High byte leaves first.
						oe_d = rword_q[15];
					end
				end
				backlight_cfg_pkg::ST_RDATA: begin
					cnt_d = cnt_q + 3'h1;
					if (cnt_q == 3'h7) begin
						oe_d    = 1'b1;
						state_d = backlight_cfg_pkg::ST_RACK;
					end else begin
						tx_d = {tx_q[6:0], 1'b0};
						oe_d = tx_q[6];
					end
				end
				backlight_cfg_pkg::ST_RACK: begin
					cnt_d = 3'h0;
					if (!bit_q && !idx_q) begin
						idx_d   = 1'b1;
						tx_d    = rword_q[7:0];
						oe_d    = rword_q[7];
						state_d = backlight_cfg_pkg::ST_RDATA;
					end else begin
						state_d = backlight_cfg_pkg::ST_IDLE;
					end
				end
				default: begin
					state_d = backlight_cfg_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Registers of the sequencer; the link reset is synchronous to the bus clock.
	always_ff @(negedge scl_clk) begin
		if (!lrst_q2) begin
			state_q    <= backlight_cfg_pkg::ST_IDLE;
			after_q    <= backlight_cfg_pkg::ST_IDLE;
			cnt_q      <= 3'h0;
			shift_q    <= 8'h00;
			tx_q       <= 8'h00;
			hi_q       <= 8'h00;
			raddr_q    <= 8'h00;
			idx_q      <= 1'b0;
			oe_q       <= 1'b1;
			wtog_q     <= 1'b0;
			rtog_q     <= 1'b0;
			waddr_q    <= 8'h00;
			wdata_q    <= 16'h0000;
			rword_q    <= backlight_cfg_pkg::RST_READ_WORD;
			ack_seen_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			after_q    <= after_d;
			cnt_q      <= cnt_d;
			shift_q    <= shift_d;
			tx_q       <= tx_d;
			hi_q       <= hi_d;
			raddr_q    <= raddr_d;
			idx_q      <= idx_d;
			oe_q       <= oe_d;
			wtog_q     <= wtog_d;
			rtog_q     <= rtog_d;
			waddr_q    <= waddr_d;
			wdata_q    <= wdata_d;
			rword_q    <= rword_d;
			ack_seen_q <= ack_seen_d;
		end
	end

	// The pin is only ever pulled low; a one is the released line.
	always_ff @(negedge scl_clk) begin
		sda_out <= 1'b0;
	end

	assign sda_oe_b   = oe_q;
	assign wr_tog     = wtog_q;
	assign wr_addr    = waddr_q;
	assign wr_data    = wdata_q;
	assign rd_req_tog = rtog_q;
	assign rd_addr    = raddr_q;

endmodule

/* File: verif/serial_host.sv */
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Host controller model on the serial link
// -----------------------------------------------------------------
// The clock stands still between frames; bits take 30 ns each.
module serial_host #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// Bus lines, open drain with a pull-up on the bench.
	output logic      scl_clk,
	output logic      sda_drv_b,
	input  wire logic sda_line
);
	initial begin
		scl_clk   = 1'b1;
		sda_drv_b = 1'b1;
	end

	// Data moves in the low phase only, so it is stable at every rising edge.
	task automatic bit_io(input logic b, output logic s);
		#7 sda_drv_b = b;
		#8 scl_clk = 1'b1;
		s = sda_line;
		#15 scl_clk = 1'b0;
	endtask

	// Idle clock pulses with the line high, used while the link is reset.
	task automatic pulses(input int n);
		logic s;
		scl_clk = 1'b0;
		repeat (n) bit_io(1'b1, s);
	endtask

	// Start and repeated start: the line falls while the clock is high.
	// After a stop the clock rests high; the target only looks at the line on clock
	// edges, so a fall comes first and lets it close the old frame.
	task automatic start;
		if (scl_clk) begin
			#8 scl_clk = 1'b0;
		end
		#7 sda_drv_b = 1'b1;
		#8 scl_clk = 1'b1;
		#7 sda_drv_b = 1'b0;
		#8 scl_clk = 1'b0;
	endtask

	// Stop leaves both lines high and the clock still.
	task automatic stop;
		#7 sda_drv_b = 1'b0;
		#8 scl_clk = 1'b1;
		#7 sda_drv_b = 1'b1;
	endtask

	// Byte out, most significant bit first, then the acknowledge slot.
	task automatic tx(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// Byte in; the host acknowledges all but the last byte.
	task automatic rx(input logic last, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
		bit_io(last, s);
	endtask

	// Four-byte write frame, high data byte first.
	task automatic write_reg(input logic [7:0] ofs, input logic [15:0] d, output logic ok);
		logic a0, a1, a2, a3;
		start;
		tx({ADDR, 1'b0}, a0);
		tx(ofs, a1);
		tx(d[15:8], a2);
		tx(d[7:0], a3);
		stop;
		ok = a0 & a1 & a2 & a3;
	endtask

	// Five-byte read frame with a repeated start before the read address.
	task automatic read_reg(input logic [7:0] ofs, output logic [15:0] d, output logic ok);
		logic a0, a1, a2;
		start;
		tx({ADDR, 1'b0}, a0);
		tx(ofs, a1);
		start;
		tx({ADDR, 1'b1}, a2);
		rx(1'b0, d[15:8]);
		rx(1'b1, d[7:0]);
		stop;
		ok = a0 & a1 & a2;
	endtask
endmodule

/* File: verif/test_backlight_dimming_config_regs.sv */
`timescale 1ns/1ps

module test_backlight_dimming_config_regs;
	logic        clk_sys, rst_b, sda_out, sda_oe_b, ok, brt_reg, ramp_en, smooth, smooth_act;
	logic        dith_en, rnd;
	wire  logic  scl_clk, sda_drv_b, sda_line;
	logic [15:0] brt, d, w, ctrl, got_val;
	logic [1:0]  src;
	logic [11:0] level;
	logic [8:0]  ramp_ms;
	logic [2:0]  dith;
	logic [10:0] rate;
	logic [6:0]  dev;
	logic [15:0] q [$];
	int          fail_count, comparisons;
	event        got_ev;
	// Expected decodes, written out independently of the design tables.
	logic [8:0]  ms_t [8] = '{9'h000, 9'h001, 9'h002, 9'h032, 9'h064, 9'h0c8, 9'h12c, 9'h1f4};
	logic [10:0] hz_t [4] = '{11'h0c8, 11'h1f4, 11'h320, 11'h4b0};
	logic [6:0]  dv_t [4] = '{7'h21, 7'h2b, 7'h35, 7'h48};

	// Open-drain line: low when either party pulls it.
	assign sda_line = sda_drv_b & (sda_oe_b | sda_out);

	backlight_cfg_regs dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .scl_clk(scl_clk),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe_b(sda_oe_b), .brightness_value(brt),
		.brightness_from_register(brt_reg), .brightness_source_select(src),
		.string_drive_level(level), .ramp_enable(ramp_en), .ramp_linear_ms(ramp_ms),
		.smooth_ramp_enable(smooth), .smooth_ramp_active(smooth_act),
		.dither_enable(dith_en), .dither_bits(dith), .spread_modulation_rate(rate),
		.spread_deviation(dev), .random_spread_enable(rnd));
	serial_host host_u (.scl_clk(scl_clk), .sda_drv_b(sda_drv_b), .sda_line(sda_line));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// -----------------------------------------------------------------
	// Result checking
	// -----------------------------------------------------------------
	// The driver notes the expectation; the observer compares in order.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		q.push_back(exp);
		got_val = got;
		->got_ev;
		#1;
	endtask

	always @(got_ev) begin
		comparisons++;
		if (got_val !== q[0]) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got_val, q[0]);
		end
		void'(q.pop_front());
	end

	task automatic end_sim;
		$display("Mismatches %0d, comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// A hung link would stall the sequence, so a fixed limit ends the run.
	initial begin
		#300000;
		fail_count++;
		end_sim;
	end

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	initial begin
		logic [15:0] rv [3];
		logic [2:0]  dsat;
		logic        sm;
		rv = '{16'h0000, 16'h0fff, 16'h08a3};
		rst_b = 1'b0;
		void'($urandom(97));
		// The link takes reset through two flops on its falling edge, so it needs
		// pulses while reset is held and two more after release before a start.
		fork
			begin
				repeat (5) @(posedge clk_sys);
				rst_b <= 1'b1;
			end
			host_u.pulses(6);
		join
		repeat (2) @(posedge clk_sys);
		chk({ramp_ms, dev}, {9'h0c8, 7'h35});
		chk({level, src, smooth, rnd}, {12'hfff, 2'h0, 1'b1, 1'b0});
		for (int r = 0; r < 3; r++) begin
			host_u.read_reg(8'(2 * r), d, ok);
			chk(d, rv[r]);
		end
		// Every code of the rate, deviation, ramp and dither fields, source codes 0 and 2, with random filler bits.
		for (int i = 0; i < 8; i++) begin
			w = 16'($urandom);
			sm = (i == 1 || i == 2) ? 1'b0 : w[1];
			dsat = (i > 4) ? 3'h4 : 3'(i);
			ctrl = {w[15:14], 2'(i), 2'(i + 1), i[0], 1'b0, 3'(i), 3'(i), sm, w[0]};
			host_u.write_reg(8'h04, ctrl, ok);
			chk({15'h0, ok}, 16'h0001);
			repeat (8) @(posedge clk_sys);
			chk({ramp_ms, dev}, {ms_t[i], dv_t[(i + 1) % 4]});
			chk({rate, dith, smooth, rnd}, {hz_t[i % 4], dsat, sm, w[14]});
			chk({brt_reg, src, ramp_en, dith_en, smooth_act, 10'h0},
				{i[0], i[0], 1'b0, i != 0, i != 0, sm && i != 0, 10'h0});
			host_u.read_reg(8'h04, d, ok);
			chk(d, ctrl);
			w = 16'($urandom);
			host_u.write_reg(8'h00, w, ok);
			host_u.write_reg(8'h02, ~w, ok);
			repeat (8) @(posedge clk_sys);
			chk(brt, w);
			chk({4'h0, level}, {4'h0, ~w[11:0]});
		end
		// A write cut off after its high byte leaves the word as it was.
		host_u.start;
		host_u.tx({7'h2a, 1'b0}, ok);
		host_u.tx(8'h00, ok);
		host_u.tx(~w[15:8], ok);
		host_u.stop;
		host_u.read_reg(8'h00, d, ok);
		chk(d, w);
		// Unmapped offset reads back zero; a foreign address is not acknowledged.
		host_u.write_reg(8'h06, 16'h1234, ok);
		host_u.read_reg(8'h06, d, ok);
		chk(d, 16'h0000);
		host_u.start;
		host_u.tx({7'h2b, 1'b0}, ok);
		host_u.stop;
		chk({15'h0, ok}, 16'h0000);
		end_sim;
	end
endmodule
